// >>> inc/eio_pkg.sv
`default_nettype none

package eio_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 8;          // Pins on the port
    localparam int HALF_PORT = 4;          // Pins 0..3 vs pins 4..7
    localparam int SEG_TOP_BIT = 7;        // Enable bit for pin 0

    // ------------------------------------------------------------
    // Register byte addresses (aligned words)
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_DIR = 32'h0000_0000;  // pin_direction_h
    localparam logic [31:0] ADDR_PORT = 32'h0000_0004; // pin_level_h
    localparam logic [31:0] ADDR_LAT = 32'h0000_0008;  // output_latch_h
    localparam logic [31:0] ADDR_SEG = 32'h0000_000C;  // segment enable
    localparam logic [31:0] ADDR_WORD_MASK = 32'hFFFF_FFFC;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RST = 8'hFF;  // All pins inputs
    localparam logic [7:0] LAT_RST = 8'h00;  // Latch cleared
    localparam logic [7:0] SEG_RST = 8'h00;  // Segments off

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// >>> core/eio_sync.sv
`default_nettype none

// ------------------------------------------------------------
// Two-stage synchroniser for the pin inputs
// ------------------------------------------------------------
module eio_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins in, settled copy out
    input wire logic [7:0] d,
    output logic [7:0] q
);

    // Both stages in one state word
    typedef struct packed {
        logic [7:0] first;   // Metastable stage, read only by second
        logic [7:0] second;  // Settled stage
    } eio_sync_t;

    eio_sync_t st;
    eio_sync_t next_st;

    // Shift one stage per clock
    always_comb begin
        next_st = st;
        next_st.first = d;
        next_st.second = st.first;
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.second;

endmodule

`default_nettype wire

// >>> core/eio_port.sv
`default_nettype none

// Overview of operation
// - Eight pins, each direction, latch, input
// - Direction one: driver off, pin is input
// - Direction zero: pin driven from latch
// - Latch register readable; reads return latch
// - Each direction bit set independently
// - Reset leaves every pin an input
// - Port functions only with segment disabled
// - Segment enable suppresses latch drive always
// - Enable bit k selects segment forty plus k
// - Pins 0..3 take segments 47..44
// - Pins 4..7 take segments 40..43
// - Segment overrides the direction bit

module eio_port (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // AXI4-Lite write address
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Port pins, split into in, out and enable
    input wire logic [7:0] IO_PIN_IN,
    output logic [7:0] IO_PIN_OUT,
    output logic [7:0] IO_PIN_OE,
    // Pins handed to the segment driver
    output logic [7:0] LCD_SEG_ACTIVE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dir;       // pin_direction_h
        logic [7:0] lat;       // output_latch_h
        logic [7:0] se;        // lcd_segment_enable_upper
        logic aw_held;         // Write address captured
        logic [31:0] awaddr;   // Captured write address
        logic w_held;          // Write data captured
        logic [7:0] wdata;     // Captured low data byte
        logic wstrb0;          // Captured low byte lane strobe
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;     // Upper 24 bits always read zero
        logic [1:0] rresp;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] seg_act;
    } eio_state_t;

    eio_state_t st;
    eio_state_t next_st;
    logic [7:0] pin_sync;  // Settled pin levels

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Per-pin segment mask from the enable register
    function automatic logic [7:0] seg_pins(input logic [7:0] se);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < eio_pkg::PIN_COUNT; i++) begin
            if (i < eio_pkg::HALF_PORT) begin
                m[i] = se[eio_pkg::SEG_TOP_BIT - i];
            end else begin
                m[i] = se[i - eio_pkg::HALF_PORT];
            end
        end
        return m;
    endfunction

    // Address match on an aligned word
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] reg_addr);
        return (a & eio_pkg::ADDR_WORD_MASK) == reg_addr;
    endfunction

    // Mapped-address test, used by both channels
    function automatic logic mapped(input logic [31:0] a);
        return hit(a, eio_pkg::ADDR_DIR) || hit(a, eio_pkg::ADDR_PORT)
            || hit(a, eio_pkg::ADDR_LAT) || hit(a, eio_pkg::ADDR_SEG);
    endfunction

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    eio_sync u_sync (
        .clk(MCLK),
        .rst(SYS_RST),
        .d(IO_PIN_IN),
        .q(pin_sync)
    );

    // Handshake terms
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic do_write;
    assign aw_fire = AWVALID && st.awready;
    assign w_fire = WVALID && st.wready;
    assign ar_fire = ARVALID && st.arready;
    assign do_write = st.aw_held && st.w_held && !st.bvalid;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] seg;
        seg = 8'h00;
        next_st = st;
        // Capture address and data in either order
        if (aw_fire) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = AWADDR;
        end
        if (w_fire) begin
            next_st.w_held = 1'b1;
            next_st.wdata = WDATA[7:0];
            next_st.wstrb0 = WSTRB[0];
        end
        // Perform the write once both halves are here
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.awaddr) ? eio_pkg::RESP_OKAY
                                              : eio_pkg::RESP_SLVERR;
            // Only the low byte lane carries register bits
            if (st.wstrb0) begin
                if (hit(st.awaddr, eio_pkg::ADDR_DIR)) begin
                    next_st.dir = st.wdata;
                end
                if (hit(st.awaddr, eio_pkg::ADDR_LAT)) begin
                    next_st.lat = st.wdata;
                end
                if (hit(st.awaddr, eio_pkg::ADDR_PORT)) begin
                    next_st.lat = st.wdata;
                end
                if (hit(st.awaddr, eio_pkg::ADDR_SEG)) begin
                    next_st.se = st.wdata;
                end
            end
        end
        // Response leaves when the master takes it
        if (st.bvalid && BREADY) begin
            next_st.bvalid = 1'b0;
        end
        // Accept a new half only while no write is pending
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        // Read: answer one cycle after the address is taken
        if (ar_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(ARADDR) ? eio_pkg::RESP_OKAY
                                           : eio_pkg::RESP_SLVERR;
            if (hit(ARADDR, eio_pkg::ADDR_DIR)) begin
                next_st.rdata = st.dir;
            end else if (hit(ARADDR, eio_pkg::ADDR_PORT)) begin
                next_st.rdata = pin_sync;
            end else if (hit(ARADDR, eio_pkg::ADDR_LAT)) begin
                next_st.rdata = st.lat;
            end else if (hit(ARADDR, eio_pkg::ADDR_SEG)) begin
                next_st.rdata = st.se;
            end else begin
                next_st.rdata = 8'h00;     // Unmapped reads zero
            end
        end else if (st.rvalid && RREADY) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;
        // Pin drive from the new register values, so the pins
        // change at the same edge as the register write
        seg = seg_pins(next_st.se);
        next_st.seg_act = seg;
        // Segment wins over direction; direction one releases
        next_st.pin_oe = ~next_st.dir & ~seg;
        next_st.pin_out = next_st.lat & next_st.pin_oe;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st <= '0;
            st.dir <= eio_pkg::DIR_RST;
            st.lat <= eio_pkg::LAT_RST;
            st.se <= eio_pkg::SEG_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AWREADY = st.awready;
    assign WREADY = st.wready;
    assign BVALID = st.bvalid;
    assign BRESP = st.bresp;
    assign ARREADY = st.arready;
    assign RVALID = st.rvalid;
    assign RRESP = st.rresp;
    assign RDATA = {24'h000000, st.rdata};
    assign IO_PIN_OUT = st.pin_out;
    assign IO_PIN_OE = st.pin_oe;
    assign LCD_SEG_ACTIVE = st.seg_act;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    // Write of a byte on the low lane to a given register
    logic wr_lane;
    assign wr_lane = do_write && st.wstrb0;

    property p_reset_inputs;
        $past(SYS_RST) |-> IO_PIN_OE == 8'h00 ##1 IO_PIN_OE == 8'h00;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("Pin driven right after reset");

    property p_dir_hiz;
        (IO_PIN_OE & st.dir) == 8'h00;
    endproperty
    a_dir_hiz: assert property (p_dir_hiz)
        else $error("Input pin has its driver on");

    property p_drive_latch;
        ((IO_PIN_OUT ^ st.lat) & IO_PIN_OE) == 8'h00;
    endproperty
    a_drive_latch: assert property (p_drive_latch)
        else $error("Driven pin differs from latch");

    property p_seg_top;
        st.se[7] |-> LCD_SEG_ACTIVE[0] && !IO_PIN_OE[0];
    endproperty
    a_seg_top: assert property (p_seg_top)
        else $error("Enable bit 7 not on pin 0");

    property p_seg_low;
        st.se[0] && !st.se[3] |-> LCD_SEG_ACTIVE[4]
            && !LCD_SEG_ACTIVE[7];
    endproperty
    a_seg_low: assert property (p_seg_low)
        else $error("Enable bit 0 not on pin 4 alone");

    property p_seg_override;
        st.se[5] && !st.dir[2] |-> !IO_PIN_OE[2];
    endproperty
    a_seg_override: assert property (p_seg_override)
        else $error("Segment pin still driven");

    property p_gpio_usable;
        !st.se[5] && !st.dir[2] |-> IO_PIN_OE[2];
    endproperty
    a_gpio_usable: assert property (p_gpio_usable)
        else $error("Output pin not driven");

    property p_dir_stable;
        !(wr_lane && hit(st.awaddr, eio_pkg::ADDR_DIR)) |=>
            $stable(st.dir);
    endproperty
    a_dir_stable: assert property (p_dir_stable)
        else $error("Direction changed without its write");

    property p_port_write;
        wr_lane && hit(st.awaddr, eio_pkg::ADDR_PORT) |=>
            st.lat == $past(st.wdata) ##1 IO_PIN_OUT[7:0] ==
            ($past(st.wdata, 2) & IO_PIN_OE);
    endproperty
    a_port_write: assert property (p_port_write)
        else $error("Port write missed the latch");

    property p_lat_read;
        ar_fire && hit(ARADDR, eio_pkg::ADDR_LAT) |=>
            RVALID && RDATA == {24'h000000, $past(st.lat)};
    endproperty
    a_lat_read: assert property (p_lat_read)
        else $error("Latch read did not return latch");

    property p_sync_lag;
        !$past(SYS_RST) && !$past(SYS_RST, 2) |->
            pin_sync == $past(IO_PIN_IN, 2);
    endproperty
    a_sync_lag: assert property (p_sync_lag)
        else $error("Pin input not two cycles late");

    property p_bvalid_hold;
        BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("Write response dropped early");

    c_seg_on: cover property (st.se[7] ##1 LCD_SEG_ACTIVE[0]);
    c_pin_drive: cover property (IO_PIN_OE != 8'h00);
    c_port_read: cover property (ar_fire
        && hit(ARADDR, eio_pkg::ADDR_PORT) ##1 RVALID);

endmodule

`default_nettype wire

// >>> tb/eio_board.sv
`default_nettype none

// ------------------------------------------------------------
// Board circuitry on the port pins
// ------------------------------------------------------------
module eio_board (
    // Device pin drive
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // Level the board puts on each pin
    input wire logic [7:0] ext_level,
    // Resolved wire level back to the device
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Board sources are resistive, so a driven pin wins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the shared port
// ------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and bus
    logic mclk, sys_rst;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, r;
    // Pins and the bench model of the registers
    logic [7:0] pin_in, pin_out, pin_oe, seg_act, ext;
    logic [7:0] m_dir, m_lat, m_se, d, l, s;
    logic [31:0] junk;
    int errors, tests_run;

    eio_port eio_port_i (.MCLK(mclk), .SYS_RST(sys_rst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .IO_PIN_IN(pin_in), .IO_PIN_OUT(pin_out), .IO_PIN_OE(pin_oe),
        .LCD_SEG_ACTIVE(seg_act));
    eio_board eio_board_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));

    // Free-running 40 MHz clock
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    // Pin k of the low half takes enable bit 7-k, high half bit k-4
    function automatic logic [7:0] segmap(input logic [7:0] se);
        logic [7:0] m;
        for (int i = 0; i < 8; i++) begin
            m[i] = (i < 4) ? se[7 - i] : se[i - 4];
        end
        return m;
    endfunction

    // Pins the device should drive
    function automatic logic [7:0] exp_oe();
        return ~m_dir & ~segmap(m_se);
    endfunction

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Data comparison
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Response code comparison
    task automatic chk_resp(input string nm, input logic [1:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ------------------------------------------------------------
    // Bus master; a wait that runs out ends the run
    // ------------------------------------------------------------
    task automatic axw(input logic [31:0] a, dd, input logic [3:0] st,
                       output logic [1:0] rs);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= dd;
        wstrb <= st;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'h0;
        if (n == 40) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic axr(input logic [31:0] a, output logic [31:0] dd,
                       output logic [1:0] rs);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        dd = rdata;
        rs = rresp;
        rready <= 1'h0;
        if (n == 40) begin
            errors++;
            end_sim();
        end
    endtask

    // Write with junk in the unused upper bits, expect OKAY
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        logic [1:0] rs;
        junk = $urandom;
        axw(a, {junk[31:8], v}, 4'hF, rs);
        chk_resp("bresp", eio_pkg::RESP_OKAY, rs);
    endtask

    // Read, expect OKAY and the given word
    task automatic rd(input string nm, input logic [31:0] a, e);
        logic [31:0] dd;
        logic [1:0] rs;
        axr(a, dd, rs);
        chk_resp("rresp", eio_pkg::RESP_OKAY, rs);
        chk(nm, e, dd);
    endtask

    // Pin outputs against the model, once settled
    task automatic chk_pins();
        #1;
        chk("pin_oe", {24'h0, exp_oe()}, {24'h0, pin_oe});
        chk("pin_out", {24'h0, m_lat & exp_oe()}, {24'h0, pin_out});
        chk("seg_act", {24'h0, segmap(m_se)}, {24'h0, seg_act});
    endtask

    // Register readback against the model
    task automatic chk_regs();
        rd("dir", eio_pkg::ADDR_DIR, {24'h0, m_dir});
        rd("latch", eio_pkg::ADDR_LAT, {24'h0, m_lat});
        rd("seg", eio_pkg::ADDR_SEG, {24'h0, m_se});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        junk = $urandom(32'h0BD2);
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        ext = 8'h5A;
        sys_rst = 1'h1;
        errors = 0;
        tests_run = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'h0;
        m_dir = eio_pkg::DIR_RST;
        m_lat = 8'h00;
        m_se = 8'h00;
        @(posedge mclk);
        chk_pins();
        chk_regs();
        // Corner cases first, then random settings
        for (int k = 0; k < 40; k++) begin
            {d, l, s} = {8'($urandom), 8'($urandom), 8'($urandom)};
            if (k == 0) {d, l, s} = 24'h00_A5_00;
            if (k == 1) {d, l, s} = 24'h00_FF_FF;
            if (k == 2) {d, l, s} = 24'h7F_FF_01;
            wr(eio_pkg::ADDR_DIR, d);
            // Odd passes load the latch through the port address
            wr(k[0] ? eio_pkg::ADDR_PORT : eio_pkg::ADDR_LAT, l);
            wr(eio_pkg::ADDR_SEG, s);
            {m_dir, m_lat, m_se} = {d, l, s};
            // New board levels launched on this clock edge
            ext <= 8'($urandom);
            chk_pins();
            repeat (2) @(posedge mclk);
            rd("pins", eio_pkg::ADDR_PORT,
               {24'h0, (m_lat & exp_oe()) | (ext & ~exp_oe())});
            chk_regs();
        end
        // Byte lane off: nothing changes
        axw(eio_pkg::ADDR_LAT, {24'h0, ~m_lat}, 4'hE, r);
        chk_resp("bresp", eio_pkg::RESP_OKAY, r);
        // Unmapped place refused both ways
        axw(32'h0000_0010, 32'h0000_00FF, 4'hF, r);
        chk_resp("bresp", eio_pkg::RESP_SLVERR, r);
        axr(32'h0000_0010, junk, r);
        chk_resp("rresp", eio_pkg::RESP_SLVERR, r);
        chk("rdata", 32'h0, junk);
        chk_regs();
        chk_pins();
        end_sim();
    end
endmodule

`default_nettype wire
